// ==== rtl/icem_defines.svh ====
`ifndef ICEM_DEFINES_SVH
`define ICEM_DEFINES_SVH

// Data path widths
`define ICEM_CNT_W       24
`define ICEM_TALLY_W     16
`define ICEM_NCH         8
`define ICEM_ADDR_W      8

// Register byte offsets
`define ICEM_OFS_CTRL    8'h00
`define ICEM_OFS_COUNT   8'h04
`define ICEM_OFS_SHADOW  8'h08
`define ICEM_OFS_CAPA    8'h0C
`define ICEM_OFS_CAPB    8'h10
`define ICEM_OFS_TALLY   8'h14
`define ICEM_OFS_NOTIFY  8'h18
`define ICEM_OFS_IRQEN   8'h1C

// Control register fields
`define ICEM_F_EN        0
`define ICEM_F_MODE_LO   1
`define ICEM_F_MODE_HI   2
`define ICEM_F_LSEL      4
`define ICEM_F_LIGN      5
`define ICEM_F_XSTR      6
`define ICEM_F_ROUTE     7
`define ICEM_F_SSA_LO    8
`define ICEM_F_SSA_HI    9
`define ICEM_F_SSB_LO    10
`define ICEM_F_SSB_HI    11
`define ICEM_F_XSA       12
`define ICEM_F_XSB       13
`define ICEM_F_SHSEL     14
`define ICEM_F_CLK_LO    16
`define ICEM_F_CLK_HI    18
`define ICEM_CTRL_MASK   32'h0007_7FF7

// Notify and enable bit positions
`define ICEM_N_NEWVAL    0
`define ICEM_N_OVERRUN   1
`define ICEM_N_CNTWRAP   2
`define ICEM_N_TALLYWRAP 3

// Reset values
`define ICEM_RST_CTRL    32'h0000_0000
`define ICEM_RST_SHADOW  24'h00_0000
`define ICEM_RST_IRQEN   4'h0

`endif

// ==== rtl/icem_pkg.sv ====
`include "icem_defines.svh"

package icem_pkg;

  typedef enum logic [1:0] {
    ICEM_PULSE_INT,
    ICEM_EDGE_COUNT,
    ICEM_PRESCALE,
    ICEM_BIT_COMPRESS
  } icem_mode_t;

  typedef enum logic {
    ICEM_BUS_IDLE,
    ICEM_BUS_WAIT
  } icem_bus_t;

  // Per-cycle view of the filter outputs of all channels
  typedef struct packed {
    logic [`ICEM_NCH-1:0] filtered_input;
    logic [`ICEM_NCH-1:0] rise_detect;
    logic [`ICEM_NCH-1:0] fall_detect;
  } icem_sense_t;

  typedef struct packed {
    logic [`ICEM_CNT_W-1:0] base2;
    logic [`ICEM_CNT_W-1:0] base1;
    logic [`ICEM_CNT_W-1:0] base0;
  } icem_tbase_t;

  // Word handed to the routing unit
  typedef struct packed {
    logic                   overrun;
    logic                   level;
    logic [`ICEM_CNT_W-1:0] word_b;
    logic [`ICEM_CNT_W-1:0] word_a;
  } icem_route_t;

  typedef struct packed {
    icem_bus_t                bus;
    logic [`ICEM_ADDR_W-1:0]  addr;
    logic                     write;
    logic [31:0]              hrdata;
    logic                     hready;
    logic                     hresp;
    logic [31:0]              ctrl;
    logic [`ICEM_CNT_W-1:0]   shadow_count;
    logic [3:0]               irq_en;
    logic [3:0]               notify;
    logic [3:0]               irq;
    logic [`ICEM_CNT_W-1:0]   channel_counter;
    logic [`ICEM_CNT_W-1:0]   capture_reg_a;
    logic [`ICEM_CNT_W-1:0]   capture_reg_b;
    logic [`ICEM_TALLY_W-1:0] edge_tally;
    logic                     unread;
    logic                     strobe_prev;
    logic                     rt_valid;
    icem_route_t              rt_data;
  } icem_state_t;

endpackage

// ==== rtl/icem_channel.sv ====
// Operation
// - Ext-strobe integration: capture, new value, clear
// - Integrate on tick only at selected level
// - Edge counting: select rising, falling or both
// - Each counted edge sets new-value flag
// - Counted edge loads both captures and shadow
// - Unconsumed capture overwritten sets overrun flag
// - Counter wrap in edge mode sets flag
// - Edge counting ignores clock tick select
// - Ext-strobe edge mode: qualified strobe counts
// - Prescaler fires after shadow plus one edges
// - Prescaler edge choice; ignores tick select
// - Prescaler fire updates both capture registers
// - Ext prescaler counts strobes, compares shadow
// - Bit compression only on channel zero
// - Shadow bits pick rise/fall sample events
// - Sample event stores inputs in capture B
// - Capture A holds selected timestamp
// - Routing sends sample word with timestamp
// - Edge tally counts every new-value event; code tallies every prescaler event and pulse-mode edge_ok
// - Edge tally wrap sets its flag
// - Bit compression ignores tick select
// - Ext strobe rising edge gates all updates; code still counts ticks at the selected level between strobes in pulse mode
// - Enabling channel clears channel counter
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
module icem_channel
  import icem_pkg::*;
#(
  parameter bit IS_CHANNEL_ZERO = 1'b1
) (
  // Clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // AHB-Lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic      [31:0]              hrdata,
  output logic                          hresp,
  // Filtered inputs, strobe, ticks and time bases
  input  wire icem_sense_t              sense,
  input  wire logic                     external_strobe,
  input  wire logic [`ICEM_NCH-1:0]     clk_tick,
  input  wire icem_tbase_t              tbase,
  // Routing unit
  output logic                          route_valid,
  output icem_route_t                   route_data,
  input  wire logic                     route_ready,
  // Enabled notify flags
  output logic      [3:0]               irq_flags
);

  icem_state_t s;
  icem_state_t n;

  function automatic logic [`ICEM_CNT_W-1:0] pick_src(
    input logic [1:0]               sel,
    input logic                     ext,
    input logic [`ICEM_CNT_W-1:0]   alt,
    input logic [`ICEM_CNT_W-1:0]   cnt,
    input logic [`ICEM_TALLY_W-1:0] tally,
    input icem_tbase_t              tb
  );
    logic [`ICEM_CNT_W-1:0] v;
    v = alt;
    if (ext) begin
      // The tally is narrower than a capture word: pad with zeros
      if (sel == 2'b00) begin
        v = {{(`ICEM_CNT_W-`ICEM_TALLY_W){1'b0}}, tally};
      end else begin
        v = cnt;
      end
    end else begin
      case (sel)
        2'b00:   v = tb.base0;
        2'b01:   v = tb.base1;
        2'b10:   v = tb.base2;
        default: v = alt;
      endcase
    end
    return v;
  endfunction

  logic                     ch_en;
  icem_mode_t               mode;
  logic                     lsel;
  logic                     lign;
  logic                     xstr;
  logic                     level;
  logic                     tick;
  logic                     strobe_rise;
  logic                     strobe_ok;
  logic                     edge_ok;
  logic                     sample_ev;
  logic                     ev;
  logic                     do_cap;
  logic                     do_inc;
  logic                     do_clr;
  logic                     do_shadow;
  logic                     tally_inc;
  logic                     consumed;
  logic                     route_take;
  logic                     bus_take;
  logic                     bus_done;
  logic                     en_write;
  logic [3:0]               set_flags;
  logic [3:0]               clr_flags;
  logic [`ICEM_CNT_W:0]     cnt_sum;
  logic [`ICEM_TALLY_W:0]   tally_sum;
  logic [`ICEM_CNT_W-1:0]   new_a;
  logic [`ICEM_CNT_W-1:0]   new_b;
  logic [31:0]              rd_word;

  always_comb begin
    n = s;
    ch_en = s.ctrl[`ICEM_F_EN];
    mode  = icem_mode_t'(s.ctrl[`ICEM_F_MODE_HI:`ICEM_F_MODE_LO]);
    lsel  = s.ctrl[`ICEM_F_LSEL];
    lign  = s.ctrl[`ICEM_F_LIGN];
    xstr  = s.ctrl[`ICEM_F_XSTR];
    level = sense.filtered_input[0];
    tick  = clk_tick[s.ctrl[`ICEM_F_CLK_HI:`ICEM_F_CLK_LO]];
    strobe_rise = external_strobe & ~s.strobe_prev;
    // Strobe qualified by input level unless the level is ignored
    strobe_ok = strobe_rise & (lign | (level == lsel));
    // Both edges when ignored, else the edge into the selected level
    edge_ok = lign ? (sense.rise_detect[0] | sense.fall_detect[0])
                   : (lsel ? sense.rise_detect[0]
                           : sense.fall_detect[0]);
    // A shadow of zero selects no event, so the mode stays silent unless external strobe is on
    // Rise events in the low byte, fall events in the second byte (bits 15:8)
    sample_ev = |(sense.rise_detect & s.shadow_count[`ICEM_NCH-1:0]) |
                |(sense.fall_detect &
                  s.shadow_count[`ICEM_NCH+7:8]);
    // Event modes take no clock tick
    ev = xstr ? strobe_ok : edge_ok;
    do_cap    = 1'b0;
    do_inc    = 1'b0;
    do_clr    = 1'b0;
    do_shadow = 1'b0;
    tally_inc = 1'b0;

    // Each mode turns its own event into its own mix of capture, count and clear
    if (ch_en) begin
      case (mode)
        ICEM_PULSE_INT: begin
          if (xstr) begin
            // A strobe beats a tick in the same cycle; that tick is lost
            if (strobe_rise) begin
              do_cap = 1'b1;
              do_clr = 1'b1;
              do_shadow = 1'b1;
            end else if (tick && level == lsel) begin
              do_inc = 1'b1;
            end
          end else begin
            if (tick && level == lsel) begin
              do_inc = 1'b1;
            end
            // Counter stops when the level is left: publish the sum
            if (lsel ? sense.fall_detect[0] : sense.rise_detect[0]) begin
              do_cap = 1'b1;
              do_shadow = 1'b1;
            end
          end
          tally_inc = edge_ok;
        end
        ICEM_EDGE_COUNT: begin
          if (ev) begin
            do_inc    = 1'b1;
            do_cap    = 1'b1;
            do_shadow = 1'b1;
            tally_inc = 1'b1;
          end
        end
        ICEM_PRESCALE: begin
          if (ev) begin
            tally_inc = 1'b1;
            // Equality, not greater-or-equal: a shadow written below the
            // count runs on until the counter wraps
            if (s.channel_counter == s.shadow_count) begin
              do_cap = 1'b1;
              do_clr = 1'b1;
            end else begin
              do_inc = 1'b1;
            end
          end
        end
        ICEM_BIT_COMPRESS: begin
          // Needs every filter output, so only channel zero has it
          if (IS_CHANNEL_ZERO) begin
            if (xstr ? strobe_ok : sample_ev) begin
              do_cap    = 1'b1;
              tally_inc = 1'b1;
            end
          end
        end
        default: begin
          do_cap = 1'b0;
        end
      endcase
    end

    cnt_sum   = {1'b0, s.channel_counter} + {{`ICEM_CNT_W{1'b0}}, 1'b1};
    tally_sum = {1'b0, s.edge_tally} + {{`ICEM_TALLY_W{1'b0}}, 1'b1};

    new_a = pick_src(s.ctrl[`ICEM_F_SSA_HI:`ICEM_F_SSA_LO],
                     s.ctrl[`ICEM_F_XSA], s.shadow_count,
                     s.channel_counter, s.edge_tally, tbase);
    if (mode == ICEM_BIT_COMPRESS) begin
      // Source select B has no say here
      new_b = {{(`ICEM_CNT_W-`ICEM_NCH){1'b0}},
               sense.filtered_input};
    end else begin
      new_b = pick_src(s.ctrl[`ICEM_F_SSB_HI:`ICEM_F_SSB_LO],
                       s.ctrl[`ICEM_F_XSB], s.channel_counter,
                       s.channel_counter, s.edge_tally, tbase);
    end

    // Bus access: one wait state on every transfer lets read data come
    // from a register instead of a decoder in front of hrdata
    bus_take = hsel & htrans[1] & hready & (s.bus == ICEM_BUS_IDLE);
    bus_done = (s.bus == ICEM_BUS_WAIT);
    // Only a 0 to 1 change of the enable bit restarts the count
    en_write = bus_done & s.write & (s.addr == `ICEM_OFS_CTRL) &
               ~ch_en & hwdata[`ICEM_F_EN];
    // Unmapped offsets read as zero
    case (s.addr)
      `ICEM_OFS_CTRL:   rd_word = s.ctrl;
      `ICEM_OFS_COUNT:  rd_word = {8'h00, s.channel_counter};
      `ICEM_OFS_SHADOW: rd_word = {8'h00, s.shadow_count};
      `ICEM_OFS_CAPA:   rd_word = {8'h00, s.capture_reg_a};
      `ICEM_OFS_CAPB:   rd_word = {8'h00, s.capture_reg_b};
      `ICEM_OFS_TALLY:  rd_word = {16'h0000, s.edge_tally};
      `ICEM_OFS_NOTIFY: rd_word = {28'h000_0000, s.notify};
      `ICEM_OFS_IRQEN:  rd_word = {28'h000_0000, s.irq_en};
      default:          rd_word = 32'h0000_0000;
    endcase
    n.hresp = 1'b0;
    clr_flags = 4'h0;
    route_take = s.rt_valid & route_ready;
    consumed   = route_take;
    case (s.bus)
      ICEM_BUS_IDLE: begin
        if (bus_take) begin
          n.bus    = ICEM_BUS_WAIT;
          n.addr   = haddr[`ICEM_ADDR_W-1:0];
          // Narrow writes are dropped; reads of any size are answered
          n.write  = hwrite & (hsize == 3'b010);
          n.hready = 1'b0;
        end
      end
      ICEM_BUS_WAIT: begin
        n.bus    = ICEM_BUS_IDLE;
        n.hready = 1'b1;
        // Full-word writes answer zero, so no stale read value leaks out
        n.hrdata = s.write ? 32'h0000_0000 : rd_word;
        if (!s.write && (s.addr == `ICEM_OFS_CAPA ||
                         s.addr == `ICEM_OFS_CAPB)) begin
          consumed = 1'b1;
        end
        if (s.write) begin
          case (s.addr)
            `ICEM_OFS_CTRL:   n.ctrl = hwdata & `ICEM_CTRL_MASK;
            `ICEM_OFS_SHADOW: n.shadow_count = hwdata[`ICEM_CNT_W-1:0];
            `ICEM_OFS_NOTIFY: clr_flags = hwdata[3:0];
            `ICEM_OFS_IRQEN:  n.irq_en = hwdata[3:0];
            default:          n.hrdata = 32'h0000_0000;
          endcase
        end
      end
      default: begin
        n.bus    = ICEM_BUS_IDLE;
        n.hready = 1'b1;
      end
    endcase

    // Channel state updates
    set_flags = 4'h0;
    // Strobe history runs in every mode, so turning external capture on
    // cannot find a stale rising edge
    n.strobe_prev = external_strobe;
    if (do_clr) begin
      n.channel_counter = {`ICEM_CNT_W{1'b0}};
    end else if (do_inc) begin
      n.channel_counter = cnt_sum[`ICEM_CNT_W-1:0];
      set_flags[`ICEM_N_CNTWRAP] = cnt_sum[`ICEM_CNT_W];
    end
    if (tally_inc) begin
      n.edge_tally = tally_sum[`ICEM_TALLY_W-1:0];
      set_flags[`ICEM_N_TALLYWRAP] = tally_sum[`ICEM_TALLY_W];
    end
    if (do_shadow) begin
      n.shadow_count = s.ctrl[`ICEM_F_SHSEL] ? tbase.base0
                                             : s.channel_counter;
    end
    if (consumed) begin
      n.unread = 1'b0;
    end
    // A CPU read frees the registers but not a word still on offer
    if (route_take) begin
      n.rt_valid = 1'b0;
    end

    if (do_cap) begin
      n.capture_reg_a = new_a;
      n.capture_reg_b = new_b;
      set_flags[`ICEM_N_NEWVAL]  = 1'b1;
      set_flags[`ICEM_N_OVERRUN] = s.unread & ~consumed;
      // New capture wins over a same-cycle consume
      n.unread = 1'b1;
      // Offered only when routing is on; the CPU may read either way
      if (s.ctrl[`ICEM_F_ROUTE]) begin
        n.rt_valid = 1'b1;
        n.rt_data.word_a  = new_a;
        n.rt_data.word_b  = new_b;
        n.rt_data.level   = level;
        n.rt_data.overrun = set_flags[`ICEM_N_OVERRUN];
      end
    end

    // Enabling by a bus write restarts accumulation from zero
    if (en_write) begin
      n.channel_counter = {`ICEM_CNT_W{1'b0}};
    end

    // Hardware set wins over write-one-to-clear
    n.notify = (s.notify & ~clr_flags) | set_flags;
    n.irq    = n.notify & n.irq_en;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{bus:             ICEM_BUS_IDLE,
             addr:            '0,
             write:           1'b0,
             hrdata:          32'h0000_0000,
             hready:          1'b1,
             hresp:           1'b0,
             ctrl:            `ICEM_RST_CTRL,
             shadow_count:    `ICEM_RST_SHADOW,
             irq_en:          `ICEM_RST_IRQEN,
             notify:          4'h0,
             irq:             4'h0,
             channel_counter: '0,
             capture_reg_a:   '0,
             capture_reg_b:   '0,
             edge_tally:      '0,
             unread:          1'b0,
             strobe_prev:     1'b0,
             rt_valid:        1'b0,
             rt_data:         '0};
    end else begin
      s <= n;
    end
  end

  // Every output is a field of the state register
  assign hreadyout   = s.hready;
  assign hrdata      = s.hrdata;
  assign hresp       = s.hresp;
  assign route_valid = s.rt_valid;
  assign route_data  = s.rt_data;
  assign irq_flags   = s.irq;

endmodule

// ==== verif/icem_channel_checker.sv ====
module icem_channel_checker
  import icem_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Events and routing
  input wire icem_sense_t sense,
  input wire logic        external_strobe,
  input wire logic        route_valid,
  input wire icem_route_t route_data,
  input wire logic        route_ready,
  input wire logic [3:0]  irq_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take;
  logic ev;
  logic ev_q;
  assign take = hsel && htrans[1] && hready && hreadyout;
  // Any event that could start a capture; a superset keeps checks safe
  assign ev = (|sense.rise_detect) || (|sense.fall_detect) || external_strobe;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_q <= 1'b0;
    end else begin
      ev_q <= ev;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_one_wait: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("wait state not one cycle");
  chk_wait_cause: assert property ($fell(hreadyout) |-> $past(take))
    else $error("wait state without transfer");
  chk_unmapped_zero: assert property (
    take && !hwrite && haddr[7:0] > 8'h1C |=> ##1 hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_route_hold: assert property (
    route_valid && !route_ready |=> route_valid)
    else $error("route word dropped unaccepted");
  chk_route_stable: assert property (
    route_valid && !route_ready && !ev |=> $stable(route_data))
    else $error("route word changed without event");
  chk_route_cause: assert property ($rose(route_valid) |-> ev_q)
    else $error("route word without event");
  chk_route_drop: assert property (
    route_valid && route_ready && !ev |=> !route_valid)
    else $error("route word kept after accept");
  cover property (route_valid && route_ready);
  cover property ($rose(irq_flags[1]));
  cover property (take && hwrite);
endmodule

bind icem_channel icem_channel_checker u_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
  .hrdata, .hresp, .sense, .external_strobe, .route_valid, .route_data,
  .route_ready, .irq_flags
);

// ==== verif/icem_route_sink.sv ====
module icem_route_sink
  import icem_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Routing handshake
  input wire logic        route_valid,
  input wire icem_route_t route_data,
  output logic            route_ready,
  // Pacing and observation
  input wire logic [3:0]  delay,
  output icem_route_t     last_word,
  output logic [15:0]     word_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      route_ready <= 1'b0;
      wait_cnt <= 4'h0;
      word_cnt <= 16'h0000;
      last_word <= '0;
    end else if (route_valid && route_ready) begin
      last_word <= route_data;
      word_cnt <= word_cnt + 16'h0001;
      route_ready <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (route_valid && wait_cnt >= delay) begin
      route_ready <= 1'b1;
    end else if (route_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// ==== verif/tb_input_channel_event_modes.sv ====
`include "icem_defines.svh"
module tb_input_channel_event_modes
  import icem_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 0;
  logic        hresetn = 0;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic        external_strobe = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 0;
  logic [7:0]  clk_tick = 0;
  logic [3:0]  delay = 0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        route_valid;
  logic        route_ready;
  logic [3:0]  irq_flags;
  logic [15:0] word_cnt;
  icem_sense_t sense = '0;
  icem_tbase_t tbase = '0;
  icem_route_t route_data;
  icem_route_t last_word;
  logic [31:0] rd;
  logic [31:0] v;
  logic [7:0]  lv = 0;
  logic [7:0]  nv;
  logic        ig;
  logic        sl;
  logic        x;
  bit          pi_on = 0;
  int          pi_cnt = 0;
  int          pi_cap = 0;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n;
  int          w;

  icem_channel u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sense(sense), .external_strobe(external_strobe),
    .clk_tick(clk_tick), .tbase(tbase), .route_valid(route_valid),
    .route_data(route_data), .route_ready(route_ready),
    .irq_flags(irq_flags)
  );
  icem_route_sink u_sink (
    .hclk(hclk), .hresetn(hresetn), .route_valid(route_valid),
    .route_data(route_data), .route_ready(route_ready), .delay(delay),
    .last_word(last_word), .word_cnt(word_cnt)
  );

  always #10 hclk = ~hclk;
  // Ticks run free; edge-driven modes must not care
  always @(posedge hclk) begin
    clk_tick <= 8'($urandom);
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // Reference count of ticks spent at the selected level
  always @(posedge hclk) begin
    if (pi_on && external_strobe) begin
      pi_cap = pi_cnt;
      pi_cnt = 0;
    end else if (pi_on && clk_tick[0] && sense.filtered_input[0]) begin
      pi_cnt++;
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    hsize <= sz;
    // Only the bench timeout ends a wait that never gets an answer
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 3'b010);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000, 3'b010);
    chk(rd, e);
  endtask
  task automatic step(input logic [7:0] nv2, input logic s);
    @(posedge hclk);
    sense <= {nv2, nv2 & ~lv, ~nv2 & lv};
    external_strobe <= s;
    lv = nv2;
    @(posedge hclk);
    sense <= {nv2, 16'h0000};
    external_strobe <= 1'b0;
  endtask
  function automatic logic [31:0] cfg(logic [1:0] m, logic i, logic s,
                                      logic e, logic r, logic [1:0] b);
    return {20'h0_0000, b, 2'b00, r, e, i, s, 1'b0, m, 1'b1};
  endfunction
  function automatic logic wanted(logic i, logic s, logic o, logic nw);
    return (o != nw) && (i || nw == s);
  endfunction

  initial begin
    void'($urandom(32'hfcca_4808));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    tbase <= {24'($urandom), 24'($urandom), 24'($urandom)};
    rdc(`ICEM_OFS_CTRL, 32'h0000_0000);
    rdc(`ICEM_OFS_SHADOW, 32'h0000_0000);
    rdc(`ICEM_OFS_IRQEN, 32'h0000_0000);
    rdc(8'h24, 32'h0000_0000);
    v = $urandom;
    wr(`ICEM_OFS_CTRL, v);
    rdc(`ICEM_OFS_CTRL, v & `ICEM_CTRL_MASK);
    xfer(1'b1, `ICEM_OFS_CTRL, ~v, 3'b000);
    rdc(`ICEM_OFS_CTRL, v & `ICEM_CTRL_MASK);
    wr(`ICEM_OFS_IRQEN, 32'h0000_000F);
    $display("test registers done");
    // Falling, rising, both, then strobe-qualified rising level
    for (int k = 0; k < 4; k++) begin
      ig = (k == 2);
      sl = (k != 0);
      x = (k == 3);
      wr(`ICEM_OFS_CTRL, 32'h0000_0000);
      wr(`ICEM_OFS_CTRL, cfg(2'd1, ig, sl, x, 1'b0, 2'b00));
      wr(`ICEM_OFS_NOTIFY, 32'h0000_000F);
      n = 0;
      repeat (12) begin
        nv = 8'($urandom);
        if (x ? nv[0] == sl : wanted(ig, sl, lv[0], nv[0])) n++;
        step(nv, x);
      end
      rdc(`ICEM_OFS_COUNT, n);
      if (n > 0) rdc(`ICEM_OFS_CAPA, tbase.base0);
      rdc(`ICEM_OFS_NOTIFY, {30'h0, n > 1, n > 0});
      chk(irq_flags, {2'b00, n > 1, n > 0});
    end
    $display("test edge counting done");
    for (int s = 0; s < 3; s += 2) begin
      wr(`ICEM_OFS_CTRL, 32'h0000_0000);
      wr(`ICEM_OFS_SHADOW, s);
      wr(`ICEM_OFS_CTRL, cfg(2'd2, 1'b1, 1'b0, s == 2, 1'b0, 2'b00));
      wr(`ICEM_OFS_NOTIFY, 32'h0000_000F);
      for (int e = 1; e <= 6; e++) begin
        step(lv ^ 8'h01, s == 2);
        @(negedge hclk);
        chk(irq_flags[0], e % (s + 1) == 0);
        if (e % (s + 1) == 0) rdc(`ICEM_OFS_CAPA, tbase.base0);
        wr(`ICEM_OFS_NOTIFY, 32'h0000_0001);
      end
    end
    $display("test prescaler done");
    wr(`ICEM_OFS_CTRL, 32'h0000_0000);
    wr(`ICEM_OFS_SHADOW, 32'h0000_0408);
    xfer(1'b0, `ICEM_OFS_TALLY, 32'h0000_0000, 3'b010);
    v = rd;
    wr(`ICEM_OFS_CTRL, cfg(2'd3, 1'b0, 1'b0, 1'b0, 1'b1, 2'b00));
    n = 0;
    repeat (24) begin
      nv = 8'($urandom);
      delay <= 4'($urandom_range(0, 7));
      w = word_cnt;
      if ((nv[3] & ~lv[3]) | (~nv[2] & lv[2])) begin
        n++;
        step(nv, 1'b0);
        for (int i = 0; i < 40 && word_cnt == w; i++) @(posedge hclk);
        chk(word_cnt, w + 1);
        chk({last_word.word_b, last_word.word_a},
            {16'h0000, nv, tbase.base0});
      end else begin
        step(nv, 1'b0);
        repeat (8) @(posedge hclk);
        chk(word_cnt, w);
      end
    end
    rdc(`ICEM_OFS_TALLY, v + n);
    $display("test bit compression done");
    step(8'h00, 1'b0);
    wr(`ICEM_OFS_CTRL, 32'h0000_0000);
    wr(`ICEM_OFS_CTRL, cfg(2'd0, 1'b0, 1'b1, 1'b1, 1'b0, 2'b11));
    pi_cnt = 0;
    pi_on = 1;
    step(8'h01, 1'b0);
    repeat (30) @(posedge hclk);
    step(8'h00, 1'b0);
    repeat (10) @(posedge hclk);
    step(8'h01, 1'b0);
    repeat (20) @(posedge hclk);
    step(8'h00, 1'b1);
    // Let the reference see the strobe edge before it stops
    @(posedge hclk);
    pi_on = 0;
    rdc(`ICEM_OFS_CAPB, pi_cap);
    rdc(`ICEM_OFS_COUNT, 32'h0000_0000);
    $display("test pulse integration done");
    print_verdict();
  end
endmodule
